// ### rtl/pio_pkg.sv
package pio_pkg;
    // ========================================================
    // register map (byte addresses on the 32-bit bus)
    // ========================================================
    // printed offsets are not word aligned, so they are indices
    localparam logic [15:0] PIO_IDX_DATA     = 16'hf238;
    localparam logic [15:0] PIO_IDX_DIR      = 16'hf239;
    localparam logic [15:0] PIO_IDX_CTRL     = 16'hf23a;
    localparam logic [15:0] PIO_IDX_FUNC     = 16'hf23c;
    localparam int          PIO_ADDR_W       = 18;
    localparam logic [17:0] PIO_ADDR_DATA    = {PIO_IDX_DATA, 2'b00};
    localparam logic [17:0] PIO_ADDR_DIR     = {PIO_IDX_DIR, 2'b00};
    localparam logic [17:0] PIO_ADDR_CTRL    = {PIO_IDX_CTRL, 2'b00};
    localparam logic [17:0] PIO_ADDR_FUNC    = {PIO_IDX_FUNC, 2'b00};

    // ========================================================
    // field layout and reset values
    // ========================================================
    localparam int          PIO_NPINS        = 8;
    localparam int          PIO_CTRL_LO_POS  = 0;
    localparam int          PIO_CTRL_HI_POS  = 8;
    localparam logic [7:0]  PIO_DATA_RST     = 8'h00;
    localparam logic [7:0]  PIO_DIR_RST      = 8'h00;
    localparam logic [15:0] PIO_CTRL_RST     = 16'h0000;
    localparam logic [15:0] PIO_FUNC_RST     = 16'h0000;
    localparam logic [1:0]  PIO_FUNC_GPIO    = 2'h0;
    localparam logic        PIO_DIR_OUT      = 1'b0;

    // drive codes in output mode
    localparam logic [1:0]  PIO_OUT_HIZ      = 2'h0;
    localparam logic [1:0]  PIO_OUT_PODR     = 2'h1;
    localparam logic [1:0]  PIO_OUT_NODR     = 2'h2;
    localparam logic [1:0]  PIO_OUT_CMOS     = 2'h3;
    // termination codes in input mode
    localparam logic [1:0]  PIO_IN_PDN       = 2'h1;
    localparam logic [1:0]  PIO_IN_PUP       = 2'h2;

    // bus answer states
    typedef enum logic [1:0] {
        PIO_IDLE = 2'b01,
        PIO_RESP = 2'b10
    } pio_bus_e;
endpackage : pio_pkg

// ### rtl/pio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// two-flop synchroniser for the pin levels
// ============================================================
module pio_sync
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // levels
    input  wire logic [7:0]       async_in,
    output logic      [7:0]       sync_out
);
    logic [7:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff  <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : pio_sync
`default_nettype wire

// ### rtl/pio_pad.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// per-pin pad decode: drive, enable and pull selection
// ============================================================
module pio_pad
    import pio_pkg::*;
(
    // configuration
    input  wire logic             out_level,
    input  wire logic             dir_in,
    input  wire logic [1:0]       code,
    input  wire logic             gpio_sel,
    // pad controls
    output logic                  pad_o,
    output logic                  pad_oe,
    output logic                  pull_up,
    output logic                  pull_dn
);
    // direction bit 0 is output, 1 input
    wire out_mode = gpio_sel && (dir_in == PIO_DIR_OUT);
    wire in_mode  = gpio_sel && (dir_in != PIO_DIR_OUT);

    // output drive: p-drain drives high only, n-drain low only
    assign pad_o  = out_level;
    assign pad_oe = out_mode && ((code == PIO_OUT_CMOS) ||
                    (code == PIO_OUT_PODR && out_level) ||
                    (code == PIO_OUT_NODR && !out_level));
    // input termination, codes 00 and 11 leave the pin floating
    assign pull_dn = in_mode && (code == PIO_IN_PDN);
    assign pull_up = in_mode && (code == PIO_IN_PUP);
endmodule : pio_pad
`default_nettype wire

// ### rtl/pio_port.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pio_port
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // avalon-mm slave
    input  wire logic [PIO_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic      [1:0]            avs_response,
    // port pins
    input  wire logic [7:0]            pin_i,
    output logic      [7:0]            pin_o,
    output logic      [7:0]            pin_oe,
    output logic      [7:0]            pin_pull_up,
    output logic      [7:0]            pin_pull_dn
);
    // ========================================================
    // registers
    // ========================================================
    logic [7:0]  pin_data_ff;
    logic [7:0]  pin_direction_ff;
    logic [15:0] pin_drive_control_ff;
    logic [15:0] pin_function_select_ff;
    logic [31:0] avs_readdata_ff;
    logic [1:0]  avs_response_ff;
    logic        avs_waitrequest_ff;
    pio_bus_e    bus_state_ff;
    logic [7:0]  pin_o_ff;
    logic [7:0]  pin_oe_ff;
    logic [7:0]  pull_up_ff;
    logic [7:0]  pull_dn_ff;

    logic [7:0]  pin_level_bits;
    logic [7:0]  nxt_o;
    logic [7:0]  nxt_oe;
    logic [7:0]  nxt_up;
    logic [7:0]  nxt_dn;

    // ========================================================
    // bus decode
    // ========================================================
    function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic       en);
        lane_merge = en ? new_v : old_v;
    endfunction : lane_merge

    wire sel_data = (avs_address == PIO_ADDR_DATA);
    wire sel_dir  = (avs_address == PIO_ADDR_DIR);
    wire sel_ctrl = (avs_address == PIO_ADDR_CTRL);
    wire sel_func = (avs_address == PIO_ADDR_FUNC);
    wire sel_any  = sel_data | sel_dir | sel_ctrl | sel_func;
    wire idle     = (bus_state_ff == PIO_IDLE);
    wire resp     = (bus_state_ff == PIO_RESP);
    // a write is taken while idle but lands in the answer cycle,
    // the edge at which the master samples waitrequest low
    wire wr_req   = idle && avs_write;
    wire wr_go    = resp && avs_write;
    wire rd_go    = idle && avs_read;

    // read mux: input pins show the synchronised level
    wire [7:0] data_view = (pin_direction_ff & pin_level_bits) |
                           (~pin_direction_ff & pin_data_ff);

    wire [31:0] rd_mux =
        sel_data ? {24'h000000, data_view} :
        sel_dir  ? {24'h000000, pin_direction_ff} :
        sel_ctrl ? {16'h0000, pin_drive_control_ff} :
        sel_func ? {16'h0000, pin_function_select_ff} : 32'h00000000;

    // ========================================================
    // synchroniser and pad decode
    // ========================================================
    // two flops before the read mux
    pio_sync u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (pin_i),
        .sync_out (pin_level_bits)
    );

    // code bits sit at the pin index, lo and hi
    // per-pin decode from direction and control code
    genvar gi;
    generate
        for (gi = 0; gi < PIO_NPINS; gi++) begin : g_pad
            pio_pad u_pad (
                .out_level (pin_data_ff[gi]),
                .dir_in    (pin_direction_ff[gi]),
                .code      ({pin_drive_control_ff[PIO_CTRL_HI_POS+gi],
                             pin_drive_control_ff[PIO_CTRL_LO_POS+gi]}),
                .gpio_sel  ({pin_function_select_ff[8+gi],
                             pin_function_select_ff[gi]} == PIO_FUNC_GPIO),
                .pad_o     (nxt_o[gi]),
                .pad_oe    (nxt_oe[gi]),
                .pull_up   (nxt_up[gi]),
                .pull_dn   (nxt_dn[gi])
            );
        end
    endgenerate

    // ========================================================
    // register writes
    // ========================================================
    // data register stored on write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_data_ff <= PIO_DATA_RST;
        end else if (wr_go && sel_data) begin
            pin_data_ff <= lane_merge(pin_data_ff, avs_writedata[7:0],
                                      avs_byteenable[0]);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_direction_ff <= PIO_DIR_RST;
        end else if (wr_go && sel_dir) begin
            pin_direction_ff <= lane_merge(pin_direction_ff,
                                avs_writedata[7:0], avs_byteenable[0]);
        end
    end

    // each byte lane updates its own half
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_drive_control_ff <= PIO_CTRL_RST;
        end else if (wr_go && sel_ctrl) begin
            pin_drive_control_ff[7:0]  <= lane_merge(
                pin_drive_control_ff[7:0], avs_writedata[7:0],
                avs_byteenable[0]);
            pin_drive_control_ff[15:8] <= lane_merge(
                pin_drive_control_ff[15:8], avs_writedata[15:8],
                avs_byteenable[1]);
        end
    end

    // function select, only code 00 routes plain io
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_function_select_ff <= PIO_FUNC_RST;
        end else if (wr_go && sel_func) begin
            pin_function_select_ff[7:0]  <= lane_merge(
                pin_function_select_ff[7:0], avs_writedata[7:0],
                avs_byteenable[0]);
            pin_function_select_ff[15:8] <= lane_merge(
                pin_function_select_ff[15:8], avs_writedata[15:8],
                avs_byteenable[1]);
        end
    end

    // ========================================================
    // bus answer: one wait cycle, then waitrequest low
    // ========================================================
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_ff       <= PIO_IDLE;
            avs_readdata_ff    <= 32'h00000000;
            avs_response_ff    <= 2'h0;
            avs_waitrequest_ff <= 1'b1;
        end else begin
            case (bus_state_ff)
                PIO_IDLE: begin
                    if (rd_go || wr_req) begin
                        bus_state_ff       <= PIO_RESP;
                        avs_readdata_ff    <= rd_go ? rd_mux : 32'h00000000;
                        avs_response_ff    <= sel_any ? 2'h0 : 2'h3;
                        avs_waitrequest_ff <= 1'b0;
                    end
                end
                PIO_RESP: begin
                    bus_state_ff       <= PIO_IDLE;
                    avs_waitrequest_ff <= 1'b1;
                end
                default: begin
                    bus_state_ff       <= PIO_IDLE;
                    avs_waitrequest_ff <= 1'b1;
                end
            endcase
        end
    end

    // ========================================================
    // pad outputs
    // ========================================================
    // registered pad controls
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_o_ff   <= 8'h00;
            pin_oe_ff  <= 8'h00;
            pull_up_ff <= 8'h00;
            pull_dn_ff <= 8'h00;
        end else begin
            pin_o_ff   <= nxt_o;
            pin_oe_ff  <= nxt_oe;
            pull_up_ff <= nxt_up;
            pull_dn_ff <= nxt_dn;
        end
    end

    // waitrequest high except in the answer cycle
    assign avs_waitrequest = avs_waitrequest_ff;
    assign avs_readdata    = avs_readdata_ff;
    assign avs_response    = avs_response_ff;
    assign pin_o           = pin_o_ff;
    assign pin_oe          = pin_oe_ff;
    assign pin_pull_up     = pull_up_ff;
    assign pin_pull_dn     = pull_dn_ff;

    // ========================================================
    // assertions
    // ========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_cmos_drive_level: assert property (
        (pin_direction_ff[0] == 1'b0 && pin_drive_control_ff[8] &&
         pin_drive_control_ff[0] && pin_function_select_ff == 16'h0000)
        |=> (pin_oe[0] && pin_o[0] == $past(pin_data_ff[0])))
        else $error("cmos pin not driven with data bit");

    a_input_no_drive: assert property (
        $past(pin_direction_ff) == 8'hff |-> pin_oe == 8'h00)
        else $error("input pin driven");

    a_hiz_code_quiet: assert property (
        $past(pin_drive_control_ff) == 16'h0000 |->
        (pin_oe == 8'h00 && pin_pull_up == 8'h00 && pin_pull_dn == 8'h00))
        else $error("code 00 not high impedance");

    a_ndrain_never_high: assert property (
        $past(pin_drive_control_ff[8] & ~pin_drive_control_ff[0]) |->
        !(pin_oe[0] && pin_o[0]))
        else $error("n-drain drove high");

    a_pull_in_only: assert property (
        (pin_pull_up | pin_pull_dn) != 8'h00 |->
        ($past(pin_direction_ff) & (pin_pull_up | pin_pull_dn)) ==
        (pin_pull_up | pin_pull_dn))
        else $error("pull active on output pin");

    a_pull_exclusive: assert property (
        (pin_pull_up & pin_pull_dn) == 8'h00)
        else $error("pull-up and pull-down together");

    a_one_wait_cycle: assert property (
        (idle && (avs_read || avs_write)) |=> !avs_waitrequest ##1
        avs_waitrequest)
        else $error("answer not one cycle after request");

    a_dir_reads_back: assert property (
        (wr_go && sel_dir && avs_byteenable[0]) |=>
        pin_direction_ff == $past(avs_writedata[7:0]))
        else $error("direction write lost");

    a_ctrl_lane_keep: assert property (
        (wr_go && sel_ctrl && !avs_byteenable[1]) |=>
        $stable(pin_drive_control_ff[15:8]))
        else $error("unselected control lane changed");

    a_data_write_lands: assert property (
        (wr_go && sel_data && avs_byteenable[0]) |=>
        pin_data_ff == $past(avs_writedata[7:0]))
        else $error("data write lost");

    a_input_reads_pin: assert property (
        (rd_go && sel_data) |=>
        (avs_readdata[7:0] & $past(pin_direction_ff)) ==
        ($past(pin_level_bits) & $past(pin_direction_ff)))
        else $error("input pin read not live level");

    a_func_gates_pad: assert property (
        $past(pin_function_select_ff[0] | pin_function_select_ff[8]) |->
        !(pin_oe[0] || pin_pull_up[0] || pin_pull_dn[0]))
        else $error("pad active with other function selected");

    c_cmos_out: cover property (pin_oe == 8'hff);
    c_pull_up: cover property (pin_pull_up != 8'h00);
    c_read_input: cover property (rd_go && sel_data &&
                                  pin_direction_ff != 8'h00);
endmodule : pio_port
`default_nettype wire

// ### dv/pio_board.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// board model: resolves the level seen on each port pin
// ============================================================
module pio_board (
    // clock
    input  wire logic       ref_clk,
    // pad controls from the port
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pull_up,
    input  wire logic [7:0] pin_pull_dn,
    // board drivers on released pins
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_lvl,
    // resolved pin levels
    output logic      [7:0] pin_lvl
);
    logic [7:0] float_ff = 8'h5a;

    // a floating pin wanders every cycle, never holds a level
    always_ff @(posedge ref_clk) begin
        float_ff <= ~float_ff;
    end

    // port driver first, then board driver, then resistor
    // driven and pulled levels
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (pin_oe[n])
                pin_lvl[n] = pin_o[n];
            else if (ext_en[n])
                pin_lvl[n] = ext_lvl[n];
            else if (pin_pull_up[n])
                pin_lvl[n] = 1'b1;
            else if (pin_pull_dn[n])
                pin_lvl[n] = 1'b0;
            else
                pin_lvl[n] = float_ff[n];
        end
    end
endmodule : pio_board
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pio_pkg::*;
;
    logic                  ref_clk, resetn, avs_read, avs_write;
    logic [PIO_ADDR_W-1:0] avs_address;
    logic [31:0]           avs_writedata, avs_readdata, seed, r, q, rd;
    logic [3:0]            avs_byteenable;
    logic                  avs_waitrequest;
    logic [1:0]            avs_response, rs;
    logic [7:0]            pin_i, pin_o, pin_oe, pin_pull_up, pin_pull_dn;
    logic [7:0]            ext_en, ext_lvl, m_data, m_dir;
    logic [15:0]           m_ctrl, m_func;
    logic [23:0]           ep;
    int                    n_fail, checks;

    // ========================================================
    // clock, design and board
    // ========================================================
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    pio_port pio_port_inst (.ref_clk(ref_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn));
    pio_board pio_board_inst (.ref_clk(ref_clk), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
        .pin_pull_dn(pin_pull_dn), .ext_en(ext_en), .ext_lvl(ext_lvl),
        .pin_lvl(pin_i));

    // ========================================================
    // helpers
    // ========================================================
    task automatic results();
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [17:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        rs = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            $display("[FAIL] waitrequest exp 0 got %b", avs_waitrequest);
        end
        @(posedge ref_clk);
    endtask : bus

    task automatic rd_chk(input string nm, input logic [17:0] a,
                          input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, e & m, rd & m);
        chk("response", 32'h0, {30'h0, rs});
    endtask : rd_chk

    // expected {oe, pull_up, pull_dn} from the register model
    function automatic logic [23:0] exp_pad(input logic [7:0] da, di,
                                            input logic [15:0] c, f);
        logic [1:0] cd;
        logic [7:0] oe, pu, pd;
        for (int n = 0; n < 8; n++) begin
            cd = {c[n+8], c[n]};
            oe[n] = ~(f[n] | f[n+8]) & ~di[n] & ((cd == 2'h3) |
                    ((cd == 2'h1) & da[n]) | ((cd == 2'h2) & ~da[n]));
            pu[n] = ~(f[n] | f[n+8]) & di[n] & (cd == 2'h2);
            pd[n] = ~(f[n] | f[n+8]) & di[n] & (cd == 2'h1);
        end
        return {oe, pu, pd};
    endfunction : exp_pad

    // program all registers, then check pads and read-back
    task automatic cfg(input logic [7:0] d, di, input logic [15:0] c, f,
                       input logic [3:0] cbe);
        logic [7:0] lv, mk;
        bus(1'b1, PIO_ADDR_DATA, {24'h0, d}, 4'h1);
        bus(1'b1, PIO_ADDR_DIR, {24'h0, di}, 4'h1);
        bus(1'b1, PIO_ADDR_CTRL, {16'h0, c}, cbe);
        bus(1'b1, PIO_ADDR_FUNC, {16'h0, f}, 4'h3);
        m_data = d;
        m_dir  = di;
        m_func = f;
        if (cbe[0]) m_ctrl[7:0] = c[7:0];
        if (cbe[1]) m_ctrl[15:8] = c[15:8];
        repeat (3) @(posedge ref_clk);
        ep = exp_pad(m_data, m_dir, m_ctrl, m_func);
        chk("pads", {8'h0, ep}, {8'h0, pin_oe, pin_pull_up, pin_pull_dn});
        chk("pin_o", {24'h0, m_data & ep[23:16]}, {24'h0, pin_o & pin_oe});
        lv = (ext_en & ext_lvl) | (~ext_en & ep[15:8]);
        mk = ~m_dir | ext_en | ep[15:8] | ep[7:0];
        rd_chk("data", PIO_ADDR_DATA, {24'h0, (m_data & ~m_dir) | (lv & m_dir)}, {24'h0, mk});
        rd_chk("dir", PIO_ADDR_DIR, {24'h0, m_dir}, 32'hff);
        rd_chk("ctrl", PIO_ADDR_CTRL, {16'h0, m_ctrl}, 32'hffff);
        rd_chk("func", PIO_ADDR_FUNC, {16'h0, m_func}, 32'hffff);
    endtask : cfg

    // ========================================================
    // watchdog and main sequence
    // ========================================================
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        results();
    end

    initial begin
        seed = 32'h535e9590;
        {resetn, avs_read, avs_write} = 3'b000;
        avs_address = '0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        {ext_en, ext_lvl, m_data, m_dir} = 32'h0;
        {m_ctrl, m_func} = 32'h0;
        n_fail = 0;
        checks = 0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk("reset pads", 32'h0, {8'h0, pin_oe, pin_pull_up, pin_pull_dn});
        rd_chk("dir", PIO_ADDR_DIR, 32'h0, 32'hff);
        rd_chk("ctrl", PIO_ADDR_CTRL, 32'h0, 32'hffff);
        rd_chk("func", PIO_ADDR_FUNC, 32'h0, 32'hffff);
        rd_chk("data", PIO_ADDR_DATA, 32'h0, 32'hff);
        // unmapped place: error answer, no side effect
        bus(1'b1, 18'h3fffc, 32'hffffffff, 4'hf);
        chk("unmapped write", 32'h3, {30'h0, rs});
        bus(1'b0, 18'h3fffc, 32'h0, 4'hf);
        chk("unmapped read", 32'h3, {30'h0, rs});
        chk("unmapped data", 32'h0, rd);
        rd_chk("dir", PIO_ADDR_DIR, 32'h0, 32'hff);
        // led on pin 2 by n-drain, converter input on pin 0 kept hiz out
        cfg(8'h00, 8'h00, 16'hfefa, 16'h0, 4'h3);
        // every code in both directions
        ext_en  <= 8'h0f;
        ext_lvl <= 8'h3c;
        for (int k = 0; k < 8; k++) begin
            cfg(8'h5a, {8{k[2]}}, {{8{k[1]}}, {8{k[0]}}}, 16'h0, 4'h3);
        end
        // random configurations, lane writes and function selects
        repeat (60) begin
            r = $random(seed);
            q = $random(seed);
            ext_en  <= r[7:0];
            ext_lvl <= r[15:8];
            cfg(r[23:16], r[31:24], q[15:0],
                (q[17:16] == 2'h0) ? q[31:16] : 16'h0,
                {2'b00, q[18] ? 2'b11 : (q[19] ? 2'b10 : 2'b01)});
        end
        results();
    end
endmodule : testbench
`default_nettype wire
